/* File: src/cmpreg_pkg.sv */
// Package: register map, field layout and reset values of the comparator regs
package cmpreg_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG    = 12'h0300;
  localparam logic [11:0] CMPREG_OFF_INTERRUPT_ENABLE_SET_REG = 12'h0304;
  localparam logic [11:0] CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG = 12'h0308;
  localparam logic [11:0] CMPREG_OFF_RESULT   = 12'h0400;
  localparam logic [11:0] CMPREG_OFF_ENABLE   = 12'h0500;
  localparam logic [11:0] CMPREG_OFF_PINSEL   = 12'h0504;
  localparam logic [11:0] CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG   = 12'h0508;
  localparam logic [11:0] CMPREG_OFF_EVSTAT   = 12'h0600;
  localparam logic [11:0] CMPREG_OFF_EVMASK   = 12'h0604;
  // ==========================================================================
  // Field layout
  localparam int CMPREG_NEV       = 4;
  localparam int CMPREG_EV_READY  = 0;
  localparam int CMPREG_EV_DOWN   = 1;
  localparam int CMPREG_EV_UP     = 2;
  localparam int CMPREG_EV_CROSS  = 3;
  localparam int CMPREG_EN_W      = 2;
  localparam int CMPREG_SEL_W     = 3;
  localparam logic [1:0] CMPREG_EN_OFF = 2'h0;
  localparam logic [1:0] CMPREG_EN_ON  = 2'h2;
  // ==========================================================================
  // Reset values
  localparam logic [3:0]  CMPREG_RST_EV  = 4'h0;
  localparam logic [1:0]  CMPREG_RST_EN  = 2'h0;
  localparam logic [2:0]  CMPREG_RST_SEL = 3'h0;
  localparam logic [31:0] CMPREG_ZERO    = 32'h0000_0000;
endpackage

/* File: src/cmpreg_sticky.sv */
// Sticky event bit: set wins over write-one-to-clear
`timescale 1ns/100ps
module cmpreg_sticky (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic set_i,
  input  wire logic clr_i,
  // State
  output logic      flag_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end
endmodule

/* File: src/cmpreg_top.sv */
// Comparator register slice: APB slave, interrupt enables, result, enable
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Writing ones to the set register enables matching event interrupts.
// - Writing ones to the clear register disables matching event interrupts.
// - Outcome register captures comparator output when sample task fires.
// - Outcome bit is 0 when input below threshold, 1 when above.
// - Any-crossing fires on up or down crossing; up fires only upward.
// - Combined enable register reads and writes the same enable bits.
module cmpreg_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator core side
  input  wire logic        cmp_out,
  input  wire logic        cmp_ready,
  input  wire logic        sample_task,
  output logic             cmp_on,
  output logic      [2:0]  pin_sel,
  output logic      [2:0]  ref_sel,
  // Interrupt
  output logic             irq
);
  import cmpreg_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [3:0]  combined_interrupt_enable_reg;
    logic [1:0]  enable;
    logic        result;
    logic [2:0]  pinsel;
    logic [2:0]  reference_source_select_reg;
    logic [3:0]  evmask;
    logic [31:0] rdata;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        cmp_prev;
    logic        rdy_s1;
    logic        rdy_s2;
    logic        rdy_prev;
  } cmpreg_state_t;

  cmpreg_state_t st_q;
  cmpreg_state_t st_d;

  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        ev_up;
  logic        ev_down;
  logic        ev_ready;
  logic [3:0]  ev_set;
  logic [3:0]  ev_clr;
  logic [3:0]  ev_stat;
  logic [31:0] rd_mux;

  // ==========================================================================
  // Bus decode; the slave always answers in the access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG, CMPREG_OFF_INTERRUPT_ENABLE_SET_REG, CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG,
      CMPREG_OFF_RESULT, CMPREG_OFF_ENABLE, CMPREG_OFF_PINSEL,
      CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG, CMPREG_OFF_EVSTAT, CMPREG_OFF_EVMASK:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // ==========================================================================
  // Event detection on synchronised comparator output
  // Both edge detectors compare the second stage with cmp_prev, never the first
  assign ev_up    = st_q.cmp_s2 && !st_q.cmp_prev && st_q.enable == CMPREG_EN_ON;
  assign ev_down  = !st_q.cmp_s2 && st_q.cmp_prev && st_q.enable == CMPREG_EN_ON;
  assign ev_ready = st_q.rdy_s2 && !st_q.rdy_prev;

  always_comb begin
    ev_set = CMPREG_RST_EV;
    ev_set[CMPREG_EV_READY] = ev_ready;
    ev_set[CMPREG_EV_DOWN]  = ev_down;
    ev_set[CMPREG_EV_UP]    = ev_up;
    ev_set[CMPREG_EV_CROSS] = ev_up || ev_down;
    ev_clr = (wr_acc && paddr == CMPREG_OFF_EVSTAT)
           ? pwdata[CMPREG_NEV-1:0] : CMPREG_RST_EV;
  end

  genvar gi;
  generate
    for (gi = 0; gi < CMPREG_NEV; gi++) begin : g_ev
      cmpreg_sticky u_sticky (
        .pclk    (pclk),
        .presetn (presetn),
        .set_i   (ev_set[gi]),
        .clr_i   (ev_clr[gi]),
        .flag_q  (ev_stat[gi])
      );
    end
  endgenerate

  // Interrupt needs both the event enable and the status mask bit
  assign irq = |(ev_stat & st_q.combined_interrupt_enable_reg & st_q.evmask);

  // ==========================================================================
  // Read mux
  always_comb begin
    rd_mux = CMPREG_ZERO;
    case (paddr)
      CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG,
      CMPREG_OFF_INTERRUPT_ENABLE_SET_REG,
      CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG: rd_mux[CMPREG_NEV-1:0] = st_q.combined_interrupt_enable_reg;
      CMPREG_OFF_RESULT:   rd_mux[0] = st_q.result;
      CMPREG_OFF_ENABLE:   rd_mux[CMPREG_EN_W-1:0] = st_q.enable;
      CMPREG_OFF_PINSEL:   rd_mux[CMPREG_SEL_W-1:0] = st_q.pinsel;
      CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG:   rd_mux[CMPREG_SEL_W-1:0] = st_q.reference_source_select_reg;
      CMPREG_OFF_EVSTAT:   rd_mux[CMPREG_NEV-1:0] = ev_stat;
      CMPREG_OFF_EVMASK:   rd_mux[CMPREG_NEV-1:0] = st_q.evmask;
      default:             rd_mux = CMPREG_ZERO;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.cmp_s1   = cmp_out;
    st_d.cmp_s2   = st_q.cmp_s1;
    st_d.cmp_prev = st_q.cmp_s2;
    st_d.rdy_s1   = cmp_ready;
    st_d.rdy_s2   = st_q.rdy_s1;
    st_d.rdy_prev = st_q.rdy_s2;
    // Read data is fetched in setup so prdata is a flop in the access cycle
    if (rd_acc) begin
      st_d.rdata = rd_mux;
    end
    // Sample task comes from same-clock logic; takes the synchronised level
    if (sample_task) begin
      st_d.result = st_q.cmp_s2;
    end
    if (wr_acc) begin
      case (paddr)
        CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG:
          st_d.combined_interrupt_enable_reg = pwdata[CMPREG_NEV-1:0];
        CMPREG_OFF_INTERRUPT_ENABLE_SET_REG:
          st_d.combined_interrupt_enable_reg = st_q.combined_interrupt_enable_reg | pwdata[CMPREG_NEV-1:0];
        CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG:
          st_d.combined_interrupt_enable_reg = st_q.combined_interrupt_enable_reg & ~pwdata[CMPREG_NEV-1:0];
        CMPREG_OFF_ENABLE:
          st_d.enable = pwdata[CMPREG_EN_W-1:0];
        CMPREG_OFF_PINSEL:
          st_d.pinsel = pwdata[CMPREG_SEL_W-1:0];
        CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG:
          st_d.reference_source_select_reg = pwdata[CMPREG_SEL_W-1:0];
        CMPREG_OFF_EVMASK:
          st_d.evmask = pwdata[CMPREG_NEV-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.combined_interrupt_enable_reg    <= CMPREG_RST_EV;
      st_q.enable   <= CMPREG_RST_EN;
      st_q.result   <= 1'b0;
      st_q.pinsel   <= CMPREG_RST_SEL;
      st_q.reference_source_select_reg   <= CMPREG_RST_SEL;
      st_q.evmask   <= CMPREG_RST_EV;
      st_q.rdata    <= CMPREG_ZERO;
      st_q.cmp_s1   <= 1'b0;
      st_q.cmp_s2   <= 1'b0;
      st_q.cmp_prev <= 1'b0;
      st_q.rdy_s1   <= 1'b0;
      st_q.rdy_s2   <= 1'b0;
      st_q.rdy_prev <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign cmp_on  = (st_q.enable == CMPREG_EN_ON);
  assign pin_sel = st_q.pinsel;
  assign ref_sel = st_q.reference_source_select_reg;

  // ==========================================================================
  // Checks: interrupt enable set, clear and direct access

  a_combined_interrupt_enable_reg_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_SET_REG |=>
      (st_q.combined_interrupt_enable_reg & $past(pwdata[CMPREG_NEV-1:0]))
        == $past(pwdata[CMPREG_NEV-1:0]))
    else $error("enable set write did not set bits");

  a_set_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_SET_REG |=>
      ($past(st_q.combined_interrupt_enable_reg) & ~st_q.combined_interrupt_enable_reg) == CMPREG_RST_EV)
    else $error("enable set write cleared a bit");

  a_set_rd: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_SET_REG |=>
      prdata[CMPREG_NEV-1:0] == $past(st_q.combined_interrupt_enable_reg))
    else $error("enable set readback mismatch");

  a_combined_interrupt_enable_reg_clr: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG |=>
      (st_q.combined_interrupt_enable_reg & $past(pwdata[CMPREG_NEV-1:0])) == CMPREG_RST_EV)
    else $error("enable clear write did not clear bits");

  a_clr_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG |=>
      (st_q.combined_interrupt_enable_reg & ~$past(st_q.combined_interrupt_enable_reg)) == CMPREG_RST_EV)
    else $error("enable clear write set a bit");

  a_clr_rd: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG |=>
      prdata[CMPREG_NEV-1:0] == $past(st_q.combined_interrupt_enable_reg))
    else $error("enable clear readback mismatch");

  a_irq_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG
      && pwdata[CMPREG_NEV-1:0] == 4'hf |=> !irq)
    else $error("interrupt stays up with all enables cleared");

  a_combined_interrupt_enable_reg_dir: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG |=>
      st_q.combined_interrupt_enable_reg == $past(pwdata[CMPREG_NEV-1:0]))
    else $error("combined enable write not taken");

  a_combined_interrupt_enable_reg_rd: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG |=>
      prdata[CMPREG_NEV-1:0] == $past(st_q.combined_interrupt_enable_reg))
    else $error("combined enable readback mismatch");

  // ==========================================================================
  // Checks: compare outcome

  a_result_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sample_task |=> $stable(st_q.result))
    else $error("result changed without sample");

  a_result_rd: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == CMPREG_OFF_RESULT |=>
      prdata == {31'h0000_0000, $past(st_q.result)})
    else $error("result readback mismatch");

  a_result_val: assert property (
    @(posedge pclk) disable iff (!presetn)
    sample_task |=> st_q.result == $past(st_q.cmp_s2))
    else $error("result does not follow comparator");

  // ==========================================================================
  // Checks: comparator enable

  a_cmp_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_ENABLE
      && pwdata[CMPREG_EN_W-1:0] == CMPREG_EN_ON |=> cmp_on)
    else $error("comparator not on after enable");

  a_cmp_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_ENABLE
      && pwdata[CMPREG_EN_W-1:0] == CMPREG_EN_OFF |=> !cmp_on)
    else $error("comparator still on after disable");

  a_enable_wr: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_ENABLE |=>
      st_q.enable == $past(pwdata[CMPREG_EN_W-1:0]))
    else $error("enable field write not taken");

  // ==========================================================================
  // Checks: crossing and ready events

  a_cross_up: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev_up |=> ev_stat[CMPREG_EV_CROSS] && ev_stat[CMPREG_EV_UP])
    else $error("up crossing missed cross event");

  a_cross_down: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev_down |=> ev_stat[CMPREG_EV_CROSS] && ev_stat[CMPREG_EV_DOWN])
    else $error("down crossing missed cross event");

  a_up_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev_down |-> !ev_up)
    else $error("up event raised on a downward crossing");

  a_ev_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.enable != CMPREG_EN_ON |-> !ev_up && !ev_down)
    else $error("crossing event while comparator off");

  a_ready_ev: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev_ready |=> ev_stat[CMPREG_EV_READY])
    else $error("ready event not recorded");

  a_evstat_clr: assert property (
    @(posedge pclk) disable iff (!presetn)
    ev_clr != CMPREG_RST_EV |=>
      (ev_stat & $past(ev_clr) & ~$past(ev_set)) == CMPREG_RST_EV)
    else $error("event status not cleared by write");

  // ==========================================================================
  // Checks: bus behaviour and plain registers

  a_pready_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready)
    else $error("slave did not answer in access phase");

  a_slverr_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !psel |-> !pslverr)
    else $error("error response outside a transfer");

  a_slverr_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && paddr == CMPREG_OFF_RESULT |-> !pslverr)
    else $error("error response on a mapped register");

  a_rd_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && !addr_ok |=> prdata == CMPREG_ZERO)
    else $error("unmapped read returned data");

  a_rdata_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rd_acc |=> $stable(prdata))
    else $error("read data moved without a read");

  a_acc_excl: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc |-> !rd_acc)
    else $error("read and write decoded together");

  a_pinsel_wr: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_PINSEL |=>
      pin_sel == $past(pwdata[CMPREG_SEL_W-1:0]))
    else $error("pin select write not taken");

  a_reference_source_select_reg_wr: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG |=>
      ref_sel == $past(pwdata[CMPREG_SEL_W-1:0]))
    else $error("reference select write not taken");
endmodule

/* File: testbench/comparator_irq_result_regs_bench.sv */
// Self-checking bench for the comparator register slice
`timescale 1ns/100ps
module comparator_irq_result_regs_bench;
  import cmpreg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, wv;
  logic        pready, pslverr, err, cmp_out, cmp_ready, sample_task;
  logic        cmp_on, irq, v;
  logic [2:0]  pin_sel, ref_sel;
  logic [3:0]  ien;
  int          n_errors, checked;
  cmpreg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_out(cmp_out),
    .cmp_ready(cmp_ready), .sample_task(sample_task), .cmp_on(cmp_on),
    .pin_sel(pin_sel), .ref_sel(ref_sel), .irq(irq));
  // ==========================================================================
  // Clock, helpers
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] word(input logic [3:0] f);
    return {28'h000_0000, f};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic wait_ev();
    repeat (6) @(posedge pclk);
  endtask
  // Registered outputs settle after the edge that writes them
  task automatic settle();
    @(negedge pclk);
  endtask
  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog: the tests need a few hundred cycles
  initial begin
    #(50 * 20000);
    n_errors++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, cmp_out, cmp_ready, sample_task} = '0;
    paddr = '0; pwdata = '0; presetn = 1'b0; seed = 32'h7bc2_a99d;
    n_errors = 0; checked = 0; ien = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(CMPREG_OFF_INTERRUPT_ENABLE_SET_REG, CMPREG_ZERO);
    rdchk(CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG, CMPREG_ZERO);
    rdchk(CMPREG_OFF_ENABLE, CMPREG_ZERO);
    rdchk(CMPREG_OFF_RESULT, CMPREG_ZERO);
    settle();
    check({31'h0, cmp_on}, 32'h0);
    $display("test reset done");
    // Random set, clear and direct writes against a shared enable model
    for (int i = 0; i < 16; i++) begin
      v = xs() > 32'h5555_5555;
      wv = xs();
      if (!v) begin
        apb(1'b1, CMPREG_OFF_INTERRUPT_ENABLE_SET_REG, wv);
        ien = ien | wv[3:0];
      end else if (wv[31]) begin
        apb(1'b1, CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG, wv);
        ien = ien & ~wv[3:0];
      end else begin
        apb(1'b1, CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG, wv);
        ien = wv[3:0];
      end
      rdchk(CMPREG_OFF_INTERRUPT_ENABLE_SET_REG, word(ien));
      rdchk(CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG, word(ien));
      rdchk(CMPREG_OFF_COMBINED_INTERRUPT_ENABLE_REG, word(ien));
    end
    $display("test enables done");
    // Outcome is held until the next sample, even if the input moves
    for (int i = 0; i < 6; i++) begin
      v = xs() > 32'h7fff_ffff;
      cmp_out <= v;
      wait_ev();
      sample_task <= 1'b1;
      @(posedge pclk);
      sample_task <= 1'b0;
      cmp_out <= ~v;
      wait_ev();
      rdchk(CMPREG_OFF_RESULT, {31'h0, v});
    end
    apb(1'b1, CMPREG_OFF_RESULT, 32'hffff_ffff);
    rdchk(CMPREG_OFF_RESULT, {31'h0, v});
    $display("test result done");
    apb(1'b1, CMPREG_OFF_ENABLE, word(4'h2));
    settle();
    check({31'h0, cmp_on}, 32'h1);
    rdchk(CMPREG_OFF_ENABLE, word(4'h2));
    // Crossing events and the interrupt
    apb(1'b1, CMPREG_OFF_EVSTAT, 32'h0000_000f);
    apb(1'b1, CMPREG_OFF_INTERRUPT_ENABLE_SET_REG, 32'h0000_000f);
    apb(1'b1, CMPREG_OFF_EVMASK, 32'h0000_000f);
    cmp_out <= ~cmp_out;
    wait_ev();
    rdchk(CMPREG_OFF_EVSTAT, word(cmp_out ? 4'hc : 4'ha));
    check({31'h0, irq}, 32'h1);
    apb(1'b1, CMPREG_OFF_EVMASK, 32'h0000_0000);
    settle();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, CMPREG_OFF_EVMASK, 32'h0000_000f);
    apb(1'b1, CMPREG_OFF_EVSTAT, 32'h0000_000f);
    settle();
    check({31'h0, irq}, 32'h0);
    cmp_out <= ~cmp_out;
    cmp_ready <= 1'b1;
    wait_ev();
    rdchk(CMPREG_OFF_EVSTAT, word(cmp_out ? 4'hd : 4'hb));
    apb(1'b1, CMPREG_OFF_INTERRUPT_ENABLE_CLEAR_REG, 32'h0000_000f);
    settle();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, CMPREG_OFF_ENABLE, CMPREG_ZERO);
    settle();
    check({31'h0, cmp_on}, 32'h0);
    $display("test events done");
    // Select registers reach their outputs and read back
    for (int i = 0; i < 4; i++) begin
      wv = xs();
      apb(1'b1, CMPREG_OFF_PINSEL, wv);
      apb(1'b1, CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG, ~wv);
      rdchk(CMPREG_OFF_PINSEL, {29'h0, wv[2:0]});
      check({31'h0, err}, 32'h0);
      rdchk(CMPREG_OFF_REFERENCE_SOURCE_SELECT_REG, {29'h0, ~wv[2:0]});
      settle();
      check({29'h0, pin_sel}, {29'h0, wv[2:0]});
      check({29'h0, ref_sel}, {29'h0, ~wv[2:0]});
    end
    $display("test selects done");
    // Unmapped place answers with an error and reads zero
    rdchk(12'h0_0fc, CMPREG_ZERO);
    check({31'h0, err}, 32'h1);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
